//--- hdl/flash_erase_command_sequencer.sv
// Host-side erase controller: AHB-Lite registers in front, flash command pins behind.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "fc_cfg.svh"
module flash_erase_command_sequencer
   import fc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output flash_pins_s      flash,
   input  wire logic [7:0]  dq_in,
   input  wire logic        ready_busy_n_out
);
   // Bus side state.
   ahb_ap_s     ap_r, ap_nxt;
   logic [31:0] hrdata_nxt;
   logic [2:0]  req_op_r, req_op_nxt;
   logic        req_v_r, req_v_nxt;
   logic        hwrst_v_r, hwrst_v_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic [8:0]  count_r, count_nxt;
   logic        refused_r, refused_nxt;
   logic        mem_we;
   // Sequencer state.
   seq_e        st_r, st_nxt;
   mode_e       mode_r, mode_nxt;
   flash_pins_s pins_r, pins_nxt;
   logic [2:0]  op_r, op_nxt;
   logic [2:0]  step_r, step_nxt;
   logic [7:0]  idx_r, idx_nxt;
   logic [11:0] cnt_r, cnt_nxt;
   logic [7:0]  data_r, data_nxt;
   logic        req_ack, hwrst_ack, refuse, list_clr;
   logic [7:0]  mem_q;
   logic [8:0]  sync_q;
   logic [7:0]  dq_s;
   logic        rb_s;
   logic        wr_ok;
   logic [27:0] word;

   fc_sync #(.W(9)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({ready_busy_n_out, dq_in}),
      .q     (sync_q)
   );
   assign dq_s = sync_q[7:0];
   assign rb_s = sync_q[8];

   fc_sector_mem u_mem (
      .clk     (clk),
      .rst_b   (rst_b),
      .we      (mem_we),
      .waddr   (count_r[7:0]),
      .wdata   (hwdata[7:0]),
      .raddr   (idx_nxt),
      .rdata_r (mem_q)
   );

   // Address and data of one command write; sector number lands on address bits 19..12.
   function automatic logic [27:0] seq_word(input logic [2:0] o, input logic [2:0] s,
                                            input logic [7:0] sect_no);
      logic [19:0] a;
      logic [7:0]  d;
      a = (s == 3'h1 || s == 3'h4) ? `FC_UNLOCK2 : `FC_UNLOCK1;
      d = (s == 3'h1 || s == 3'h4) ? `FC_D_55 : `FC_D_AA;
      if (s == 3'h2) begin
         d = (o == `FC_OP_AUTO) ? `FC_D_AUTO : `FC_D_SETUP;
      end
      if (s == 3'h5) begin
         d = (o == `FC_OP_CHIP) ? `FC_D_CHIP : `FC_D_SECT;
         if (o == `FC_OP_SECT) begin
            a = {sect_no, 12'h000};
         end
      end
      if (s == 3'h0) begin
         unique case (o)
            `FC_OP_SUSP:   d = `FC_D_SUSP;
            `FC_OP_RESUME: d = `FC_D_RESUME;
            `FC_OP_RSTCMD: d = `FC_D_RESET;
            default:       d = `FC_D_AA;
         endcase
      end
      return {a, d};
   endfunction

   // Register bus: zero wait states, always OKAY, read data prepared in the address phase.
   assign wr_ok = ap_r.valid && ap_r.write;
   always_comb begin
      ap_nxt      = '0;
      hrdata_nxt  = hrdata;
      req_op_nxt  = req_op_r;
      req_v_nxt   = req_v_r && !req_ack;
      hwrst_v_nxt = hwrst_v_r && !hwrst_ack;
      addr_nxt    = addr_r;
      count_nxt   = count_r;
      refused_nxt = refused_r;
      mem_we      = 1'b0;
      if (hsel && htrans[1] && hready) begin
         ap_nxt.valid = hsize == 3'h2;
         ap_nxt.write = hwrite;
         ap_nxt.addr  = haddr[4:0];
         unique case (haddr[4:0])
            `FC_REG_CTRL:   hrdata_nxt = {23'h0, hwrst_v_r, 5'h00, req_op_r};
            `FC_REG_STATUS: hrdata_nxt = {7'h00, count_r, data_r, 1'b0, refused_r, 1'b0, 3'(mode_r), rb_s,
                                          st_r != S_IDLE};
            `FC_REG_ADDR:   hrdata_nxt = {12'h000, addr_r};
            `FC_REG_DATA:   hrdata_nxt = {24'h000000, data_r};
            default:        hrdata_nxt = 32'h00000000;
         endcase
      end
      if (wr_ok) begin
         unique case (ap_r.addr)
            `FC_REG_CTRL: begin
               if (!req_v_r && hwdata[2:0] != `FC_OP_NONE) begin
                  req_op_nxt = hwdata[2:0];
                  req_v_nxt  = 1'b1;
               end
               if (hwdata[`FC_CTRL_HWRST]) begin
                  hwrst_v_nxt = 1'b1;
               end
            end
            `FC_REG_STATUS: begin
               if (hwdata[`FC_ST_REFUSED]) begin
                  refused_nxt = 1'b0;
               end
            end
            `FC_REG_SECT: begin
               // Sectors queue in any order; one entry per write, up to every sector.
               if (!count_r[8] && st_r == S_IDLE && mode_r == M_READ) begin
                  mem_we    = 1'b1;
                  count_nxt = count_r + 9'h001;
               end
            end
            `FC_REG_ADDR: addr_nxt = hwdata[19:0];
            default: ;
         endcase
      end
      if (list_clr) begin
         count_nxt = 9'h000;
      end
      if (refuse) begin
         refused_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ap_r      <= '0;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         req_op_r  <= `FC_OP_NONE;
         req_v_r   <= 1'b0;
         hwrst_v_r <= 1'b0;
         addr_r    <= `FC_ADDR_RESET;
         count_r   <= 9'h000;
         refused_r <= 1'b0;
      end else begin
         ap_r      <= ap_nxt;
         hrdata    <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         req_op_r  <= req_op_nxt;
         req_v_r   <= req_v_nxt;
         hwrst_v_r <= hwrst_v_nxt;
         addr_r    <= addr_nxt;
         count_r   <= count_nxt;
         refused_r <= refused_nxt;
      end
   end

   // Command sequencer.
   assign word = seq_word(op_r, step_r, mem_q);
   always_comb begin
      st_nxt    = st_r;
      mode_nxt  = mode_r;
      pins_nxt  = pins_r;
      op_nxt    = op_r;
      step_nxt  = step_r;
      idx_nxt   = idx_r;
      cnt_nxt   = cnt_r;
      data_nxt  = data_r;
      req_ack   = 1'b0;
      hwrst_ack = 1'b0;
      refuse    = 1'b0;
      list_clr  = 1'b0;
      if (hwrst_v_r) begin
         // The reset pin aborts any erase; the sector list is kept for a reissue.
         hwrst_ack        = 1'b1;
         st_nxt           = S_RST;
         mode_nxt         = M_READ;
         pins_nxt         = '0;
         pins_nxt.ce_n    = 1'b1;
         pins_nxt.oe_n    = 1'b1;
         pins_nxt.we_n    = 1'b1;
         cnt_nxt          = 12'(`FC_RP_CYC - 1);
      end else begin
         unique case (st_r)
            S_IDLE: begin
               if (req_v_r) begin
                  req_ack  = 1'b1;
                  op_nxt   = req_op_r;
                  step_nxt = 3'h0;
                  idx_nxt  = 8'h00;
                  st_nxt   = S_LOAD;
                  unique case (req_op_r)
                     `FC_OP_CHIP:   refuse = mode_r != M_READ;
                     `FC_OP_SECT:   refuse = mode_r != M_READ || count_r == 9'h000;
                     `FC_OP_SUSP:   refuse = 1'b1;
                     `FC_OP_RESUME: refuse = mode_r != M_SUSP;
                     `FC_OP_RSTCMD: refuse = 1'b0;
                     `FC_OP_AUTO:   refuse = mode_r != M_READ && mode_r != M_SUSP;
                     default:       refuse = 1'b0;
                  endcase
                  if (refuse) begin
                     st_nxt = S_IDLE;
                  end else if (req_op_r == `FC_OP_READ) begin
                     // Reads during suspend return status at erasing sectors; software sorts it out.
                     pins_nxt.addr = addr_r;
                     pins_nxt.ce_n = 1'b0;
                     pins_nxt.oe_n = 1'b0;
                     cnt_nxt       = 12'(`FC_RD_CYC - 1);
                     st_nxt        = S_RLO;
                  end
               end
            end
            S_LOAD: begin
               pins_nxt.addr   = word[27:8];
               pins_nxt.dq_out = word[7:0];
               pins_nxt.dq_oe  = 1'b1;
               pins_nxt.ce_n   = 1'b0;
               pins_nxt.we_n   = 1'b0;
               cnt_nxt         = 12'(`FC_WP_CYC - 1);
               st_nxt          = S_WLO;
            end
            S_WLO: begin
               cnt_nxt = cnt_r - 12'h001;
               if (cnt_r == 12'h000) begin
                  pins_nxt.we_n = 1'b1;
                  cnt_nxt       = 12'(`FC_WPH_CYC - 1);
                  st_nxt        = S_WHI;
               end
            end
            S_WHI: begin
               cnt_nxt = cnt_r - 12'h001;
               if (cnt_r == 12'h000) begin
                  st_nxt = S_LOAD;
                  if ((op_r == `FC_OP_CHIP || op_r == `FC_OP_SECT) && step_r != 3'h5) begin
                     step_nxt = step_r + 3'h1;
                  end else if (op_r == `FC_OP_AUTO && step_r != 3'h2) begin
                     step_nxt = step_r + 3'h1;
                  end else if (op_r == `FC_OP_SECT && 9'(idx_r) + 9'h001 < count_r) begin
                     // Extra sectors follow back to back, far inside the acceptance window.
                     idx_nxt = idx_r + 8'h01;
                  end else begin
                     pins_nxt.dq_oe = 1'b0;
                     pins_nxt.ce_n  = 1'b1;
                     st_nxt         = S_IDLE;
                     unique case (op_r)
                        `FC_OP_CHIP: begin
                           mode_nxt = M_CHIP;
                           st_nxt   = S_WAIT;
                           cnt_nxt  = 12'(`FC_BUSY_CYC);
                        end
                        `FC_OP_SECT, `FC_OP_RESUME: begin
                           // Wait out the window from this rising edge before polling ready/busy.
                           mode_nxt = M_SECT;
                           st_nxt   = S_WAIT;
                           cnt_nxt  = 12'(`FC_TOUT_CYC + `FC_BUSY_CYC);
                        end
                        `FC_OP_SUSP: begin
                           mode_nxt = M_SUSP;
                           st_nxt   = S_WAIT;
                           cnt_nxt  = 12'(`FC_SUSP_CYC);
                        end
                        `FC_OP_AUTO:   mode_nxt = (mode_r == M_SUSP) ? M_SAUTO : M_AUTO;
                        `FC_OP_RSTCMD: mode_nxt = (mode_r == M_SAUTO || mode_r == M_SUSP) ? M_SUSP : M_READ;
                        default: ;
                     endcase
                  end
               end
            end
            S_RLO: begin
               cnt_nxt = cnt_r - 12'h001;
               if (cnt_r == 12'h000) begin
                  data_nxt      = dq_s;
                  pins_nxt.ce_n = 1'b1;
                  pins_nxt.oe_n = 1'b1;
                  st_nxt        = S_IDLE;
               end
            end
            S_WAIT: begin
               cnt_nxt = cnt_r - 12'h001;
               if (cnt_r == 12'h000) begin
                  st_nxt = (mode_r == M_CHIP || mode_r == M_SECT) ? S_POLL : S_IDLE;
               end
            end
            S_POLL: begin
               if (rb_s) begin
                  mode_nxt = M_READ;
                  list_clr = 1'b1;
                  st_nxt   = S_IDLE;
               end else if (req_v_r) begin
                  // Erasing: only suspend goes out, and only for a sector erase.
                  req_ack = 1'b1;
                  if (req_op_r == `FC_OP_SUSP && mode_r == M_SECT) begin
                     op_nxt   = `FC_OP_SUSP;
                     step_nxt = 3'h0;
                     st_nxt   = S_LOAD;
                  end else begin
                     refuse = 1'b1;
                  end
               end
            end
            S_RST: begin
               cnt_nxt = cnt_r - 12'h001;
               if (cnt_r == 12'h000) begin
                  if (!pins_r.reset_n) begin
                     pins_nxt.reset_n = 1'b1;
                     cnt_nxt          = 12'(`FC_RH_CYC - 1);
                  end else begin
                     st_nxt = S_IDLE;
                  end
               end
            end
            default: st_nxt = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r   <= S_IDLE;
         mode_r <= M_READ;
         pins_r <= '{addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1};
         op_r   <= `FC_OP_NONE;
         step_r <= 3'h0;
         idx_r  <= 8'h00;
         cnt_r  <= 12'h000;
         data_r <= 8'h00;
      end else begin
         st_r   <= st_nxt;
         mode_r <= mode_nxt;
         pins_r <= pins_nxt;
         op_r   <= op_nxt;
         step_r <= step_nxt;
         idx_r  <= idx_nxt;
         cnt_r  <= cnt_nxt;
         data_r <= data_nxt;
      end
   end

   assign flash = pins_r;
endmodule
`default_nettype wire

//--- include/fc_cfg.svh
// Constants for the flash erase controller: offsets, fields, reset values and timing.
// Overview of operation
// - Chip erase is six writes, then internal erase.
// - Reset pin aborts erase; host reissues afterwards.
// - Sector erase is six writes ending sector/command.
// - Host keeps extra sector writes under 50 us.
// - Other commands in window abort to array read.
// - Resume leaves suspend; repeats ignored; resuspend allowed.
// - Identification mode persists until the reset command.
`ifndef FC_CFG_SVH
`define FC_CFG_SVH

`define FC_REG_CTRL     5'h00
`define FC_REG_STATUS   5'h04
`define FC_REG_SECT     5'h08
`define FC_REG_ADDR     5'h0c
`define FC_REG_DATA     5'h10

`define FC_CTRL_HWRST   8
`define FC_ST_BUSY      0
`define FC_ST_RB        1
`define FC_ST_REFUSED   6
`define FC_ADDR_RESET   20'h00000

`define FC_OP_NONE      3'h0
`define FC_OP_CHIP      3'h1
`define FC_OP_SECT      3'h2
`define FC_OP_SUSP      3'h3
`define FC_OP_RESUME    3'h4
`define FC_OP_RSTCMD    3'h5
`define FC_OP_AUTO      3'h6
`define FC_OP_READ      3'h7

`define FC_UNLOCK1      20'h00555
`define FC_UNLOCK2      20'h002aa
`define FC_D_AA         8'haa
`define FC_D_55         8'h55
`define FC_D_SETUP      8'h80
`define FC_D_AUTO       8'h90
`define FC_D_CHIP       8'h10
`define FC_D_SECT       8'h30
`define FC_D_SUSP       8'hb0
`define FC_D_RESUME     8'h30
`define FC_D_RESET      8'hf0

`define FC_CLK_MHZ      40
`define FC_T_WP_NS      100
`define FC_T_WPH_NS     100
`define FC_T_ACC_NS     120
`define FC_T_BUSY_NS    200
`define FC_T_RP_NS      500
`define FC_T_RH_NS      200
`define FC_T_TOUT_US    50
`define FC_T_SUSP_US    20
`define FC_SYNC_LAT     2
`define FC_WP_CYC       ((`FC_T_WP_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_WPH_CYC      ((`FC_T_WPH_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_RD_CYC       ((`FC_T_ACC_NS * `FC_CLK_MHZ + 999) / 1000 + `FC_SYNC_LAT)
`define FC_BUSY_CYC     ((`FC_T_BUSY_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_RP_CYC       ((`FC_T_RP_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_RH_CYC       ((`FC_T_RH_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_TOUT_CYC     (`FC_T_TOUT_US * `FC_CLK_MHZ)
`define FC_SUSP_CYC     (`FC_T_SUSP_US * `FC_CLK_MHZ)

`endif

//--- include/fc_pkg.sv
// Types shared by the flash erase controller files.
package fc_pkg;
   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_WLO, S_WHI, S_RLO, S_WAIT, S_POLL, S_RST} seq_e;
   typedef enum logic [2:0] {M_READ, M_CHIP, M_SECT, M_SUSP, M_AUTO, M_SAUTO} mode_e;
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        reset_n;
   } flash_pins_s;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [4:0] addr;
   } ahb_ap_s;
endpackage

//--- hdl/fc_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module fc_sync #(
   parameter int W = 9
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- hdl/fc_sector_mem.sv
// Sector list memory: 256 sector numbers, registered read data.
`timescale 1ns/100ps
`default_nettype none
module fc_sector_mem (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] raddr,
   output logic      [7:0] rdata_r
);
   logic [7:0] mem [256];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

//--- verification/flash_erase_monitor.sv
// Assertion checker on the flash pins of the erase controller.
`timescale 1ns/100ps
`default_nettype none
module flash_erase_monitor
   import fc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire flash_pins_s flash,
   input wire logic        ready_busy_n_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_write_framed: assert property ($fell(flash.we_n) |-> !flash.ce_n && flash.oe_n && flash.dq_oe)
      else $error("write strobe without select or data");
   a_pulse_width: assert property ($fell(flash.we_n) |=> !flash.we_n [*3] ##1 flash.we_n)
      else $error("write pulse width wrong");
   a_high_gap: assert property ($rose(flash.we_n) |-> flash.we_n [*4])
      else $error("write strobe high time too short");
   a_addr_hold: assert property (!flash.we_n |=> $stable(flash.addr) && $stable(flash.dq_out))
      else $error("address or data moved during a write");
   a_read_len: assert property ($fell(flash.oe_n) |=> !flash.oe_n [*6] ##1 flash.oe_n)
      else $error("read strobe length wrong");
   a_no_contend: assert property (!flash.oe_n |-> flash.we_n && !flash.dq_oe && !flash.ce_n)
      else $error("read overlaps a write or data drive");
   // Only suspend or added sectors may reach a busy device; anything else would be lost.
   a_busy_cmds: assert property ($fell(flash.we_n) && !ready_busy_n_out |-> flash.dq_out inside {8'hb0, 8'h30})
      else $error("command written to a busy device");
   a_reset_pulse: assert property ($fell(flash.reset_n) |-> !flash.reset_n [*8] ##[1:30] flash.reset_n)
      else $error("hardware reset pulse wrong");
   c_suspend: cover property ($rose(flash.we_n) && flash.dq_out == 8'hb0);
   c_chip: cover property ($rose(flash.we_n) && flash.dq_out == 8'h10);
   c_reset: cover property ($fell(flash.reset_n));
endmodule
`default_nettype wire

//--- verification/flash_device_model.sv
// Behavioural model of the flash device erase logic behind the controller.
`timescale 1ns/100ps
`default_nettype none
module flash_device_model
   import fc_pkg::*;
#(
   parameter int         WIN_CYC   = 2000,
   parameter int         ERASE_CYC = 3000,
   parameter int         SUSP_LAT  = 300,
   parameter logic [7:0] MFR_CODE  = 8'h3c, // Arbitrary identity value.
   parameter logic [7:0] DEV_CODE  = 8'h6b  // Arbitrary identity value.
) (
   input  wire logic        clk,
   input  wire flash_pins_s flash,
   output logic [7:0]       dq_in,
   output logic             ready_busy_n_out
);
   mode_e        mode = M_READ;
   logic         win  = 1'b0;
   logic [2:0]   cyc  = 3'h0;
   logic [255:0] set  = '0;
   logic [7:0]   last = 8'h00;
   logic [7:0]   val;
   logic [19:0]  a;
   logic [7:0]   d;
   logic         busy, susp, tog = 1'b0, wq = 1'b1, oq = 1'b1;
   int           tmr = 0, stmr = 0;
   always_comb begin
      busy = mode == M_CHIP || mode == M_SECT;
      susp = mode == M_SUSP;
      a = flash.addr;
      d = flash.dq_out;
      if (mode == M_AUTO || mode == M_SAUTO)
         val = (a[7:0] == 8'h00) ? MFR_CODE : (a[7:0] == 8'h01) ? DEV_CODE : 8'h00;
      else if (busy || (susp && set[a[19:12]]))
         val = {susp, susp | tog, 2'h0, busy & !win, tog, 2'h0};
      else
         val = a[7:0];
      // A deselected bus shows the inverse of the last value, never a stale copy.
      dq_in = (!flash.ce_n && !flash.oe_n) ? val : ~last;
      ready_busy_n_out = !busy;
   end
   always @(posedge clk) begin
      wq <= flash.we_n;
      oq <= flash.oe_n;
      if (!flash.ce_n && !flash.oe_n) last <= val;
      if (!oq && flash.oe_n) tog <= !tog;
      if (!flash.reset_n) begin
         mode <= M_READ;
         win  <= 1'b0;
         cyc  <= 3'h0;
         set  <= '0;
         tmr  <= 0;
         stmr <= 0;
      end else begin
         if (mode == M_SECT && win) begin
            if (tmr == WIN_CYC) begin win <= 1'b0; tmr <= 0; end else tmr <= tmr + 1;
         end else if (busy) begin
            if (tmr == ERASE_CYC) begin mode <= M_READ; set <= '0; tmr <= 0; end else tmr <= tmr + 1;
         end
         if (stmr == 1) mode <= M_SUSP;
         if (stmr != 0) stmr <= stmr - 1;
         if (!wq && flash.we_n) begin
            case (mode)
               M_CHIP: ;
               M_SECT: begin
                  if (d == 8'hb0) begin
                     if (win) begin mode <= M_SUSP; win <= 1'b0; end
                     else if (stmr == 0) stmr <= SUSP_LAT;
                  end else if (win && d == 8'h30) begin set[a[19:12]] <= 1'b1; tmr <= 0; end
                  else if (win) begin mode <= M_READ; win <= 1'b0; set <= '0; end
               end
               default: begin
                  if (d == 8'hf0) begin
                     cyc <= 3'h0;
                     if (mode == M_AUTO) mode <= M_READ;
                     if (mode == M_SAUTO) mode <= M_SUSP;
                  end else if (susp && cyc == 3'h0 && d == 8'h30) mode <= M_SECT;
                  else case (cyc)
                     3'h0, 3'h3: cyc <= (a == 20'h00555 && d == 8'haa) ? cyc + 3'h1 : 3'h0;
                     3'h1, 3'h4: cyc <= (a == 20'h002aa && d == 8'h55) ? cyc + 3'h1 : 3'h0;
                     3'h2: begin
                        cyc <= (a == 20'h00555 && d == 8'h80 && mode == M_READ) ? 3'h3 : 3'h0;
                        if (a == 20'h00555 && d == 8'h90) mode <= susp ? M_SAUTO : M_AUTO;
                     end
                     default: begin
                        cyc <= 3'h0;
                        tmr <= 0;
                        if (a == 20'h00555 && d == 8'h10) mode <= M_CHIP;
                        if (d == 8'h30) begin mode <= M_SECT; win <= 1'b1; set[a[19:12]] <= 1'b1; end
                     end
                  endcase
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/flash_erase_command_sequencer_test.sv
// Self-checking bench for the flash erase controller.
`timescale 1ns/100ps
`default_nettype none
module flash_erase_command_sequencer_test
   import fc_pkg::*;
;
   localparam logic [7:0] MFR = 8'h3c; // Arbitrary identity value.
   localparam logic [7:0] DEV = 8'h6b; // Arbitrary identity value.
   logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, rb;
   logic [7:0]  dq_in;
   flash_pins_s flash;
   int          n_errors = 0, check_count = 0, cycles = 0;
   always #12.5 clk = ~clk;
   flash_erase_command_sequencer dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flash(flash), .dq_in(dq_in), .ready_busy_n_out(rb));
   flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.clk(clk), .flash(flash), .dq_in(dq_in),
      .ready_busy_n_out(rb));
   task complete_run;
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {27'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // Field order: refused, mode, ready, busy.
   task st(input logic [5:0] e);
      bus(1'b0, 5'h04, 32'h0);
      chk({26'h0, q[6], q[4:0]}, {26'h0, e});
   endtask
   task wait_idle;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 3000; i++) begin
         bus(1'b0, 5'h04, 32'h0);
         if (q[0] === 1'b0) break;
      end
   endtask
   task op(input logic [31:0] c);
      bus(1'b1, 5'h00, c);
      wait_idle();
   endtask
   task rdf(input logic [19:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b1, 5'h0c, {12'h0, a});
      op(32'h7);
      bus(1'b0, 5'h10, 32'h0);
      chk({24'h0, q[7:0] & m}, {24'h0, e});
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // The ready input needs two clocks through its synchroniser after reset.
      repeat (2) @(posedge clk);
      st(6'h02);
      bus(1'b1, 5'h14, 32'hffffffff);
      bus(1'b0, 5'h14, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 5'h0c, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
      op(32'h6);
      rdf(20'h00000, 8'hff, MFR);
      rdf(20'h00001, 8'hff, DEV);
      st(6'h12);
      op(32'h5);
      st(6'h02);
      rdf(20'h00042, 8'hff, 8'h42);
      $display("identification test done");
      bus(1'b1, 5'h00, 32'h1);
      repeat (400) @(posedge clk);
      st(6'h05);
      bus(1'b1, 5'h00, 32'h3);
      wait_idle();
      st(6'h22);
      bus(1'b1, 5'h04, 32'h40);
      op(32'h4);
      st(6'h22);
      bus(1'b1, 5'h04, 32'h40);
      st(6'h02);
      $display("chip erase test done");
      bus(1'b1, 5'h08, 32'h1f);
      bus(1'b1, 5'h08, 32'h03);
      bus(1'b1, 5'h08, 32'hff);
      bus(1'b0, 5'h04, 32'h0);
      chk({23'h0, q[24:16]}, 32'h3);
      bus(1'b1, 5'h00, 32'h2);
      repeat (2300) @(posedge clk);
      st(6'h09);
      bus(1'b1, 5'h00, 32'h5);
      repeat (20) @(posedge clk);
      st(6'h29);
      bus(1'b1, 5'h04, 32'h40);
      op(32'h3);
      st(6'h0e);
      rdf(20'h03000, 8'h80, 8'h80);
      rdf(20'h04123, 8'hff, 8'h23);
      op(32'h6);
      st(6'h16);
      rdf(20'h1f001, 8'hff, DEV);
      op(32'h5);
      st(6'h0e);
      bus(1'b1, 5'h00, 32'h4);
      repeat (100) @(posedge clk);
      st(6'h09);
      bus(1'b1, 5'h00, 32'h4);
      // The repeated resume waits out the acceptance window before it is refused.
      repeat (1950) @(posedge clk);
      st(6'h29);
      bus(1'b1, 5'h04, 32'h40);
      wait_idle();
      st(6'h02);
      bus(1'b0, 5'h04, 32'h0);
      chk({23'h0, q[24:16]}, 32'h0);
      $display("sector erase test done");
      bus(1'b1, 5'h08, 32'h05);
      bus(1'b1, 5'h00, 32'h2);
      repeat (2300) @(posedge clk);
      op(32'h100);
      st(6'h02);
      bus(1'b0, 5'h04, 32'h0);
      chk({23'h0, q[24:16]}, 32'h1);
      op(32'h2);
      st(6'h02);
      $display("hardware reset test done");
      complete_run();
   end
   // The whole sequence needs about 16500 cycles; 40000, well over twice that, means a hang.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         complete_run();
      end
   end
endmodule
bind flash_erase_command_sequencer flash_erase_monitor mon (.clk(clk), .rst_b(rst_b), .flash(flash),
   .ready_busy_n_out(ready_busy_n_out));
`default_nettype wire
